// ==== common/gpe_params.svh ====
`ifndef GPE_PARAMS_SVH
`define GPE_PARAMS_SVH

`define GPE_OFF_INDEX       5'h0E
`define GPE_OFF_STATUS      5'h10
`define GPE_OFF_ENABLE      5'h12
`define GPE_OFF_DATA        5'h14
`define GPE_OFF_RSVD        5'h18

`define GPE_IDX_NOP         16'h0000
`define GPE_IDX_GPIO_BASE   16'h0010
`define GPE_IDX_GPIO_LAST   16'h0017
`define GPE_IDX_IRQ_BASE    16'h0030
`define GPE_IDX_IRQ_LAST    16'h003F
`define GPE_IDX_GLOBAL_LOCK 16'h0040
`define GPE_IDX_SCI_IRQ     16'h0041
`define GPE_IDX_READ_EN     16'h0042
`define GPE_IDX_ATOMIC      16'h0043
`define GPE_IDX_VIDEO       16'h0050
`define GPE_IDX_SOFT_BASE   16'h0060
`define GPE_IDX_SOFT_LAST   16'h0063
`define GPE_IDX_AUDIO       16'h0064

`define GPE_TGT_NONE        8'h00
`define GPE_TGT_PWRBTN      8'h01
`define GPE_TGT_SLPBTN      8'h02
`define GPE_TGT_ALARM       8'h0A
`define GPE_TGT_GPE_HI      4'h1

`define GPE_MAP_EDGE_BIT    8
`define GPE_MAP_BOTH_BIT    9
`define GPE_MAP_WAKE_BIT    12

`define GPE_SCI_IRQ_RST     4'h9
`define GPE_IRQ8_NUM        8
`define GPE_IRQ8_MAP_RST    8'h0A

`endif

// ==== common/gpe_pkg.sv ====
package gpe_pkg;

  typedef logic [15:0] gpe_word_t;
  typedef logic [31:0] gpe_dword_t;

  typedef enum logic [3:0] {
    GPE_K_INVALID,
    GPE_K_NOP,
    GPE_K_GPIO,
    GPE_K_IRQ,
    GPE_K_GLOCK,
    GPE_K_SCI_IRQ,
    GPE_K_READ_EN,
    GPE_K_ATOMIC,
    GPE_K_VIDEO,
    GPE_K_SOFT,
    GPE_K_AUDIO
  } gpe_kind_t;

endpackage : gpe_pkg

// ==== rtl/gpe_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module gpe_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] lvl;
  logic [W-1:0] next_lvl;

  // A level is accepted only once the second and third stages agree.
  always_comb begin
    next_lvl = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);
    rise_o   = next_lvl & ~lvl;
    fall_o   = ~next_lvl & lvl;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      lvl <= '0;
    end else begin
      s1  <= pin_i;
      s2  <= s1;
      s3  <= s2;
      lvl <= next_lvl;
    end
  end

endmodule : gpe_sync

`default_nettype wire

// ==== rtl/gpe_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gpe_params.svh"

module gpe_regs #(
  parameter int N_GPIO = 8,
  parameter int N_IRQ  = 16
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic [4:0]        io_addr_i,
  input  wire logic              io_wr_i,
  input  wire logic              io_rd_i,
  input  wire gpe_pkg::gpe_dword_t io_wdata_i,
  output var gpe_pkg::gpe_dword_t io_rdata_o,
  output logic                   io_rvalid_o,
  input  wire logic [N_GPIO-1:0] gpio_i,
  input  wire logic [N_IRQ-1:0]  irq_i,
  input  wire logic              sleeping_i,
  output logic                   sci_o,
  output logic [3:0]             sci_irq_o,
  output logic                   pwr_button_o,
  output logic                   sleep_button_o,
  output logic                   alarm_wake_o,
  output logic                   global_lock_set_o,
  output logic                   power_reads_en_o,
  output logic                   atomic_io_start_o,
  output var gpe_pkg::gpe_dword_t atomic_io_addr_o,
  output logic                   soft_call_o,
  output logic [1:0]             soft_call_num_o,
  output logic                   video_power_o,
  output logic                   audio_power_o
);

  import gpe_pkg::*;

  // ------------------------------------------------------------
  // Index decoding
  // ------------------------------------------------------------
  function automatic gpe_kind_t classify(input gpe_word_t idx);
    if (idx == `GPE_IDX_NOP)
      return GPE_K_NOP;
    if (idx >= `GPE_IDX_GPIO_BASE && idx <= `GPE_IDX_GPIO_LAST)
      return GPE_K_GPIO;
    if (idx >= `GPE_IDX_IRQ_BASE && idx <= `GPE_IDX_IRQ_LAST)
      return GPE_K_IRQ;
    if (idx == `GPE_IDX_GLOBAL_LOCK)
      return GPE_K_GLOCK;
    if (idx == `GPE_IDX_SCI_IRQ)
      return GPE_K_SCI_IRQ;
    if (idx == `GPE_IDX_READ_EN)
      return GPE_K_READ_EN;
    if (idx == `GPE_IDX_ATOMIC)
      return GPE_K_ATOMIC;
    if (idx == `GPE_IDX_VIDEO)
      return GPE_K_VIDEO;
    if (idx >= `GPE_IDX_SOFT_BASE && idx <= `GPE_IDX_SOFT_LAST)
      return GPE_K_SOFT;
    if (idx == `GPE_IDX_AUDIO)
      return GPE_K_AUDIO;
    return GPE_K_INVALID;
  endfunction : classify

  function automatic logic sci_irq_ok(input logic [31:0] v);
    return (v >= 32'd3 && v <= 32'd7) || (v >= 32'd9 && v <= 32'd12) ||
           v == 32'd14 || v == 32'd15;
  endfunction : sci_irq_ok

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [N_GPIO-1:0] gpio_rise;
  logic [N_GPIO-1:0] gpio_fall;
  logic [N_IRQ-1:0]  irq_rise;

  gpe_sync #(.W(N_GPIO)) u_gpio_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .pin_i    (gpio_i),
    .rise_o   (gpio_rise),
    .fall_o   (gpio_fall)
  );

  gpe_sync #(.W(N_IRQ)) u_irq_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .pin_i    (irq_i),
    .rise_o   (irq_rise),
    .fall_o   ()
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  gpe_word_t        setup_index;
  gpe_word_t        gp_event_status;
  gpe_word_t        gp_event_enable;
  gpe_word_t        gpio_map [N_GPIO];
  logic [7:0]       irq_map  [N_IRQ];
  gpe_word_t        next_setup_index;
  gpe_word_t        next_status;
  gpe_word_t        next_enable;
  gpe_word_t        next_gpio_map [N_GPIO];
  logic [7:0]       next_irq_map  [N_IRQ];
  logic [3:0]       next_sci_irq;
  logic             next_reads_en;
  logic             next_video;
  logic             next_audio;
  logic             next_glock;
  logic             next_atomic;
  gpe_dword_t       next_atomic_addr;
  logic             next_soft;
  logic [1:0]       next_soft_num;
  logic             next_pwr;
  logic             next_slp;
  logic             next_alarm;
  gpe_word_t        ev_set;
  gpe_dword_t       next_rdata;
  gpe_kind_t        cur_kind;
  gpe_kind_t        wr_kind;
  logic             wr_index;
  logic             wr_data;
  logic [3:0]       sub;

  assign cur_kind = classify(setup_index);
  assign wr_kind  = classify(io_wdata_i[15:0]);
  assign wr_index = io_wr_i && io_addr_i == `GPE_OFF_INDEX;
  assign wr_data  = io_wr_i && io_addr_i == `GPE_OFF_DATA;
  assign sub      = setup_index[3:0];

  // ------------------------------------------------------------
  // Event routing
  // ------------------------------------------------------------
  always_comb begin
    logic edge_hit;
    logic [7:0] tgt;
    edge_hit   = 1'b0;
    tgt        = '0;
    ev_set     = '0;
    next_pwr   = 1'b0;
    next_slp   = 1'b0;
    next_alarm = 1'b0;
    for (int g = 0; g < N_GPIO; g++) begin
      tgt = gpio_map[g][7:0];
      // Both-edge sensing serves a lid switch, which must flag every change.
      edge_hit = gpio_map[g][`GPE_MAP_BOTH_BIT] ?
                 (gpio_rise[g] | gpio_fall[g]) :
                 (gpio_map[g][`GPE_MAP_EDGE_BIT] ? gpio_rise[g]
                                                  : gpio_fall[g]);
      if (gpio_map[g][`GPE_MAP_WAKE_BIT] && !sleeping_i)
        edge_hit = 1'b0;
      if (edge_hit) begin
        if (tgt[7:4] == `GPE_TGT_GPE_HI)
          ev_set[tgt[3:0]] = 1'b1;
        if (tgt == `GPE_TGT_PWRBTN)
          next_pwr = 1'b1;
        if (tgt == `GPE_TGT_SLPBTN)
          next_slp = 1'b1;
      end
    end
    // Wakeup mappings only act while the system sleeps.
    for (int i = 0; i < N_IRQ; i++) begin
      if (irq_rise[i] && sleeping_i) begin
        if (irq_map[i][7:4] == `GPE_TGT_GPE_HI)
          ev_set[irq_map[i][3:0]] = 1'b1;
        if (irq_map[i] == `GPE_TGT_ALARM)
          next_alarm = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes and commands
  // ------------------------------------------------------------
  always_comb begin
    next_setup_index = setup_index;
    next_enable      = gp_event_enable;
    next_gpio_map    = gpio_map;
    next_irq_map     = irq_map;
    next_sci_irq     = sci_irq_o;
    next_reads_en    = power_reads_en_o;
    next_video       = video_power_o;
    next_audio       = audio_power_o;
    next_glock       = 1'b0;
    next_atomic      = 1'b0;
    next_atomic_addr = atomic_io_addr_o;
    next_soft        = 1'b0;
    next_soft_num    = soft_call_num_o;
    // A set arriving with a clearing write survives the clear.
    next_status = gp_event_status;
    if (io_wr_i && io_addr_i == `GPE_OFF_STATUS)
      next_status = next_status & ~io_wdata_i[15:0];
    next_status = next_status | ev_set;
    if (io_wr_i && io_addr_i == `GPE_OFF_ENABLE)
      next_enable = io_wdata_i[15:0];
    if (wr_index && wr_kind != GPE_K_INVALID) begin
      next_setup_index = io_wdata_i[15:0];
      unique case (wr_kind)
        GPE_K_GLOCK: next_glock = 1'b1;
        GPE_K_READ_EN: next_reads_en = 1'b1;
        GPE_K_SOFT: begin
          next_soft     = 1'b1;
          next_soft_num = io_wdata_i[1:0];
        end
        default: ;
      endcase
    end
    if (wr_data) begin
      unique case (cur_kind)
        GPE_K_GPIO: next_gpio_map[sub[2:0]] = io_wdata_i[15:0];
        GPE_K_IRQ: next_irq_map[sub] = io_wdata_i[7:0];
        GPE_K_SCI_IRQ:
          if (sci_irq_ok(io_wdata_i))
            next_sci_irq = io_wdata_i[3:0];
        GPE_K_ATOMIC: begin
          next_atomic      = 1'b1;
          next_atomic_addr = io_wdata_i;
        end
        GPE_K_VIDEO:
          if (io_wdata_i <= 32'd1)
            next_video = io_wdata_i[0];
        GPE_K_AUDIO:
          if (io_wdata_i <= 32'd1)
            next_audio = io_wdata_i[0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    unique case (io_addr_i)
      `GPE_OFF_INDEX:  next_rdata = {16'h0000, setup_index};
      `GPE_OFF_STATUS: next_rdata = {16'h0000, gp_event_status};
      `GPE_OFF_ENABLE: next_rdata = {16'h0000, gp_event_enable};
      `GPE_OFF_DATA: begin
        unique case (cur_kind)
          GPE_K_GPIO: next_rdata = {16'h0000, gpio_map[sub[2:0]]};
          GPE_K_IRQ: next_rdata = {24'h000000, irq_map[sub]};
          GPE_K_SCI_IRQ: next_rdata = {28'h0000000, sci_irq_o};
          GPE_K_READ_EN: next_rdata = {31'h00000000, power_reads_en_o};
          GPE_K_ATOMIC: next_rdata = atomic_io_addr_o;
          GPE_K_VIDEO: next_rdata = {31'h00000000, video_power_o};
          GPE_K_AUDIO: next_rdata = {31'h00000000, audio_power_o};
          default: next_rdata = '0;
        endcase
      end
      default: next_rdata = '0;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      setup_index       <= 16'h0000;
      gp_event_status   <= 16'h0000;
      gp_event_enable   <= 16'h0000;
      for (int g = 0; g < N_GPIO; g++)
        gpio_map[g] <= 16'h0000;
      for (int i = 0; i < N_IRQ; i++)
        irq_map[i] <= (i == `GPE_IRQ8_NUM) ? `GPE_IRQ8_MAP_RST : 8'h00;
      sci_irq_o         <= `GPE_SCI_IRQ_RST;
      power_reads_en_o  <= 1'b0;
      video_power_o     <= 1'b0;
      audio_power_o     <= 1'b0;
      global_lock_set_o <= 1'b0;
      atomic_io_start_o <= 1'b0;
      atomic_io_addr_o  <= 32'h00000000;
      soft_call_o       <= 1'b0;
      soft_call_num_o   <= 2'h0;
      pwr_button_o      <= 1'b0;
      sleep_button_o    <= 1'b0;
      alarm_wake_o      <= 1'b0;
      sci_o             <= 1'b0;
      io_rdata_o        <= 32'h00000000;
      io_rvalid_o       <= 1'b0;
    end else begin
      setup_index       <= next_setup_index;
      gp_event_status   <= next_status;
      gp_event_enable   <= next_enable;
      gpio_map          <= next_gpio_map;
      irq_map           <= next_irq_map;
      sci_irq_o         <= next_sci_irq;
      power_reads_en_o  <= next_reads_en;
      video_power_o     <= next_video;
      audio_power_o     <= next_audio;
      global_lock_set_o <= next_glock;
      atomic_io_start_o <= next_atomic;
      atomic_io_addr_o  <= next_atomic_addr;
      soft_call_o       <= next_soft;
      soft_call_num_o   <= next_soft_num;
      pwr_button_o      <= next_pwr;
      sleep_button_o    <= next_slp;
      alarm_wake_o      <= next_alarm;
      // Level from enabled status, plus a one-cycle pulse for the lock.
      sci_o <= |(next_status & next_enable) | next_glock;
      io_rdata_o        <= io_rd_i ? next_rdata : 32'h00000000;
      io_rvalid_o       <= io_rd_i;
    end
  end

endmodule : gpe_regs

`default_nettype wire

// ==== tb/gpe_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module gpe_regs_checker (
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic [4:0]          io_addr_i,
  input  wire logic                io_wr_i,
  input  wire logic                io_rd_i,
  input  wire gpe_pkg::gpe_dword_t io_wdata_i,
  input  wire gpe_pkg::gpe_dword_t io_rdata_o,
  input  wire logic                io_rvalid_o,
  input  wire logic                sci_o,
  input  wire logic [3:0]          sci_irq_o,
  input  wire logic                global_lock_set_o,
  input  wire logic                power_reads_en_o,
  input  wire logic                atomic_io_start_o,
  input  wire gpe_pkg::gpe_dword_t atomic_io_addr_o,
  input  wire logic                soft_call_o,
  input  wire logic [1:0]          soft_call_num_o,
  input  wire logic                video_power_o,
  input  wire logic                audio_power_o
);
  import gpe_pkg::*;
  wire logic idx_wr = io_wr_i && io_addr_i == 5'h0E;
  wire logic dat_wr = io_wr_i && io_addr_i == 5'h14;
  wire logic en_cmd = idx_wr && io_wdata_i[15:0] == 16'h0042;
  wire logic [1:0] wd_lo = io_wdata_i[1:0];
  // --------------------------------------------------------------
  // Data writes are matched only shortly after their index write.
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_idx(logic [15:0] v);
    idx_wr && io_wdata_i[15:0] == v;
  endsequence
  sequence s_dat(gpe_dword_t v);
    dat_wr && io_wdata_i == v;
  endsequence
  a_read_answer: assert property (io_rd_i |=> io_rvalid_o)
    else $error("read strobe not answered");
  a_idle_zero: assert property (!io_rd_i |=> !io_rvalid_o && io_rdata_o == 0)
    else $error("read data outside answer cycle");
  a_rsvd_zero: assert property (io_rd_i && io_addr_i[4:3] == 2'b11 |=> io_rdata_o == 0)
    else $error("reserved area read not zero");
  a_glock_pulse: assert property (s_idx(16'h0040) |=> global_lock_set_o && sci_o)
    else $error("lock command gave no pulse");
  a_read_en_cause: assert property ($rose(power_reads_en_o) |-> $past(en_cmd))
    else $error("read enable without command");
  a_read_en_sticky: assert property (power_reads_en_o |=> power_reads_en_o)
    else $error("read enable dropped");
  a_sci_irq_legal: assert property (sci_irq_o inside {[3:7], [9:12], 14, 15})
    else $error("illegal interrupt line");
  a_sci_irq_take: assert property (s_idx(16'h0041) ##[1:4] s_dat(32'h5) |=> sci_irq_o == 4'h5)
    else $error("interrupt line not taken");
  a_sci_irq_keep: assert property (s_idx(16'h0041) ##[1:4] s_dat(32'h8) |=> $stable(sci_irq_o))
    else $error("invalid line changed setting");
  a_atomic_start: assert property (s_idx(16'h0043) ##[1:4] dat_wr |=> atomic_io_start_o && atomic_io_addr_o == $past(io_wdata_i))
    else $error("atomic start wrong");
  a_soft_call: assert property (idx_wr && io_wdata_i[15:2] == 14'h0018 |=> soft_call_o && soft_call_num_o == $past(wd_lo))
    else $error("service call wrong");
  a_video_on: assert property (s_idx(16'h0050) ##[1:4] s_dat(32'h1) |=> video_power_o)
    else $error("video power not on");
  a_audio_off: assert property (s_idx(16'h0064) ##[1:4] s_dat(32'h0) |=> !audio_power_o)
    else $error("audio power not off");
endmodule : gpe_regs_checker

bind gpe_regs gpe_regs_checker i_gpe_regs_checker (
  .clk_i(clk_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i),
  .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
  .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .sci_o(sci_o),
  .sci_irq_o(sci_irq_o), .global_lock_set_o(global_lock_set_o),
  .power_reads_en_o(power_reads_en_o),
  .atomic_io_start_o(atomic_io_start_o),
  .atomic_io_addr_o(atomic_io_addr_o), .soft_call_o(soft_call_o),
  .soft_call_num_o(soft_call_num_o), .video_power_o(video_power_o),
  .audio_power_o(audio_power_o));

`default_nettype wire

// ==== tb/test_gp_event_setup_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin samples_checked++; \
  if ((g) !== (e)) begin errors++; $display("FAIL %0t %s", $time, m); end end

module test_gp_event_setup_regs;
  import gpe_pkg::*;
  logic       clk_i = 0, resetn_i = 0, io_wr_i = 0, io_rd_i = 0;
  logic       sleeping_i = 0, io_rvalid_o, sci_o, global_lock_set_o;
  logic       pwr_b, slp_b, alarm, power_reads_en_o, atomic_io_start_o;
  logic       soft_call_o, video_power_o, audio_power_o;
  logic [4:0] io_addr_i = 0;
  logic [7:0] gpio_i = 0;
  logic [15:0] irq_i = 0;
  logic [3:0] sci_irq_o;
  logic [1:0] soft_call_num_o;
  gpe_dword_t io_wdata_i = 0, io_rdata_o, atomic_io_addr_o, rv;
  int errors = 0, samples_checked = 0;
  int m_idx = 0, m_sts = 0, m_set[int];
  int g, t, n, d;
  logic [4:0] d2 [7] = '{5'h0E, 5'h10, 5'h12, 5'h14, 5'h18, 5'h1C, 5'h00};
  // Pulse outputs last one cycle, so they are counted rather than sampled.
  logic [3:0] n_pwr = 0, n_slp = 0, n_alarm = 0;

  always @(posedge clk_i) begin
    if (resetn_i) begin
      n_pwr   <= n_pwr + pwr_b;
      n_slp   <= n_slp + slp_b;
      n_alarm <= n_alarm + alarm;
    end
  end

  gpe_regs i_gpe_regs (.clk_i(clk_i), .resetn_i(resetn_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .gpio_i(gpio_i), .irq_i(irq_i),
    .sleeping_i(sleeping_i), .sci_o(sci_o), .sci_irq_o(sci_irq_o),
    .pwr_button_o(pwr_b), .sleep_button_o(slp_b), .alarm_wake_o(alarm),
    .global_lock_set_o(global_lock_set_o),
    .power_reads_en_o(power_reads_en_o),
    .atomic_io_start_o(atomic_io_start_o),
    .atomic_io_addr_o(atomic_io_addr_o), .soft_call_o(soft_call_o),
    .soft_call_num_o(soft_call_num_o), .video_power_o(video_power_o),
    .audio_power_o(audio_power_o));

  initial forever #12.5 clk_i = ~clk_i;

  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------
  // Bus access: one strobe cycle, answer sampled in the next one.
  // --------------------------------------------------------------
  task automatic acc(input logic w, input logic [4:0] a, input int dv);
    @(posedge clk_i);
    #2;
    io_wr_i = w;
    io_rd_i = !w;
    io_addr_i = a;
    io_wdata_i = dv;
    @(posedge clk_i);
    #2;
    io_wr_i = 0;
    io_rd_i = 0;
    if (!w) `CHK(io_rvalid_o, 1'b1, "no read answer")
    rv = io_rdata_o;
  endtask : acc

  task automatic wr(input logic [4:0] a, input int dv);
    acc(1'b1, a, dv);
    if (a == 5'h0E && dv inside {0, [16:23], [48:67], 80, [96:100]})
      m_idx = dv;
    if (a == 5'h10) m_sts &= ~dv;
    if (a == 5'h14 && (m_idx inside {[16:23], [48:63]}
        || (m_idx == 65 && dv inside {[3:7], [9:12], 14, 15})
        || (m_idx inside {80, 100} && dv < 2))) m_set[m_idx] = dv;
  endtask : wr

  task automatic rd(input logic [4:0] a, input gpe_dword_t e);
    acc(1'b0, a, 0);
    `CHK(rv, e, "read value")
  endtask : rd

  function automatic gpe_dword_t exp_data();
    return m_set.exists(m_idx) ? m_set[m_idx] : 0;
  endfunction : exp_data

  // Events pass a synchroniser, so the wait is generous but bounded.
  task automatic wait_sci();
    int k;
    for (k = 0; k < 20 && sci_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #2;
    end
    if (k == 20) begin
      errors++;
      $display("FAIL %0t event interrupt missing", $time);
      wrap_up();
    end
  endtask : wait_sci

  initial begin
    void'($urandom(32'h4d5c17f8));
    m_set[56] = 'h0A;
    m_set[65] = 9;
    repeat (3) @(posedge clk_i);
    #2 resetn_i = 1;
    `CHK(sci_irq_o, 4'h9, "interrupt line reset")
    `CHK(power_reads_en_o, 1'b0, "read enable reset")
    wr(5'h18, 'hFFFF);
    foreach (d2[i]) rd(d2[i], 0);
    wr(5'h0E, 'h16);
    rd(5'h0E, m_idx);
    wr(5'h0E, 'h20);
    rd(5'h0E, m_idx);
    wr(5'h0E, 0);
    rd(5'h14, 0);
    wr(5'h0E, 'h38);
    rd(5'h14, exp_data());
    wr(5'h0E, 'h32);
    rd(5'h0E, m_idx);
    wr(5'h12, 'h40);
    rd(5'h12, 'h40);
    wr(5'h0E, 'h16);
    wr(5'h14, 'h316);
    rd(5'h14, exp_data());
    for (g = 0; g < 2; g++) begin
      gpio_i[6] = ~gpio_i[6];
      wait_sci();
      m_sts |= 'h40;
      rd(5'h10, m_sts);
      wr(5'h10, 0);
      rd(5'h10, m_sts);
      wr(5'h10, 'h40);
      rd(5'h10, m_sts);
      `CHK(sci_o, 1'b0, "interrupt after clear")
    end
    for (g = 0; g < 8; g++) begin
      t = $urandom_range(15);
      wr(5'h0E, 'h10 + g);
      wr(5'h14, 'h110 | t);
      rd(5'h14, exp_data());
      wr(5'h12, 1 << t);
      gpio_i[g] = 1;
      wait_sci();
      m_sts |= 1 << t;
      rd(5'h10, m_sts);
      wr(5'h10, m_sts);
      gpio_i[g] = 0;
    end
    wr(5'h0E, 'h10);
    wr(5'h14, 'h101);
    wr(5'h0E, 'h11);
    wr(5'h14, 'h102);
    wr(5'h0E, 'h12);
    wr(5'h14, 'h1115);
    gpio_i[2:0] = 3'b111;
    repeat (8) @(posedge clk_i);
    #2;
    `CHK(n_pwr, 4'h1, "power button pulse")
    `CHK(n_slp, 4'h1, "sleep button pulse")
    rd(5'h10, m_sts);
    gpio_i[2:0] = 3'b000;
    sleeping_i = 1;
    repeat (3) begin
      do n = $urandom_range(15); while (n inside {2, 8, 13});
      t = $urandom_range(15);
      wr(5'h0E, 'h30 + n);
      wr(5'h14, 'h10 | t);
      wr(5'h12, 1 << t);
      irq_i[n] = 1;
      wait_sci();
      m_sts |= 1 << t;
      rd(5'h10, m_sts);
      wr(5'h10, m_sts);
      irq_i[n] = 0;
    end
    irq_i[8] = 1;
    repeat (8) @(posedge clk_i);
    #2;
    `CHK(n_alarm, 4'h1, "alarm wake pulse")
    sleeping_i = 0;
    irq_i[n] = 1;
    repeat (8) @(posedge clk_i);
    rd(5'h10, m_sts);
    wr(5'h0E, 'h41);
    wr(5'h14, 5);
    `CHK(sci_irq_o, 4'h5, "interrupt line set")
    wr(5'h14, 8);
    rd(5'h14, exp_data());
    wr(5'h0E, 'h40);
    `CHK(global_lock_set_o & sci_o, 1'b1, "lock command")
    wr(5'h0E, 'h42);
    `CHK(power_reads_en_o, 1'b1, "read enable")
    d = $urandom;
    wr(5'h0E, 'h43);
    wr(5'h14, d);
    `CHK(atomic_io_addr_o, gpe_dword_t'(d), "atomic address")
    for (g = 0; g < 2; g++) begin
      wr(5'h0E, g ? 'h64 : 'h50);
      wr(5'h14, 1);
      wr(5'h14, 2);
      rd(5'h14, exp_data());
      `CHK(g ? audio_power_o : video_power_o, 1'b1, "power on")
      wr(5'h0E, g ? 'h64 : 'h50);
      wr(5'h14, 0);
      `CHK(g ? audio_power_o : video_power_o, 1'b0, "power off")
    end
    for (g = 0; g < 4; g++) begin
      wr(5'h0E, 'h60 + g);
      `CHK({soft_call_o, soft_call_num_o}, {1'b1, 2'(g)}, "call")
    end
    wrap_up();
  end

endmodule : test_gp_event_setup_regs

`default_nettype wire
